// ---- hdl/pd_swap_cfg.svh ----
`ifndef PD_SWAP_CFG_SVH
`define PD_SWAP_CFG_SVH

// Register offsets
`define ADDR_TOGGLE 8'hA7
`define ADDR_SINK_TX 8'hB0
`define ADDR_SRC_FRS 8'hB1
`define ADDR_SNK_FRS 8'hB2
`define ADDR_ALERT 8'hB3
`define ADDR_ALERT_MASK 8'hB4

// Reset values
`define RST_TOGGLE 8'h00
`define RST_SINK_TX 8'h40
`define RST_SRC_FRS 8'h00
`define RST_SNK_FRS 8'h00
`define RST_ALERT 8'h00
`define RST_ALERT_MASK 8'h7F

// Writable bits; everything else reads as zero
`define WMASK_TOGGLE 8'h03
`define WMASK_SINK_TX 8'h77
`define WMASK_SRC_FRS 8'h0F
`define WMASK_SNK_FRS 8'h01
`define WMASK_ALERT 8'h7F

// Field positions
`define SINK_TX_DIS_BIT 6
`define RETRY_MSB 5
`define RETRY_LSB 4
`define FRAME_MSB 2
`define FRAME_LSB 0
`define GATE_DLY_MSB 3
`define GATE_DLY_LSB 2
`define MANUAL_GATE_BIT 1
`define FRS_INIT_BIT 0
`define FRS_ARM_BIT 0
`define ALERT_RX_BIT 0
`define ALERT_TX_BIT 1

// Timing
`define CORE_CLK_MHZ 125
`define GATE_DELAY1_US 150
`define GATE_DELAY2_US 300
`define GATE_DELAY3_US 600
`define SRC_DWELL_BASE_MS 15
`define SNK_DWELL_BASE_MS 35
`define DWELL_STEP_MS 5
`define DWELL_SPAN 2

`endif

// ---- hdl/pd_swap_pkg.sv ----
package pd_swap_pkg;

  typedef enum logic [2:0] {
    FRAME_SOP = 3'h0,
    FRAME_SOP_P = 3'h1,
    FRAME_SOP_PP = 3'h2,
    FRAME_SOP_DBG_P = 3'h3,
    FRAME_SOP_DBG_PP = 3'h4,
    FRAME_HARD_RESET = 3'h5,
    FRAME_CABLE_RESET = 3'h6,
    FRAME_TEST_CARRIER = 3'h7
  } frame_type_t;

  typedef enum logic [1:0] {
    RP_NONE = 2'h0,
    RP_DEFAULT = 2'h1,
    RP_1A5 = 2'h2,
    RP_3A0 = 2'h3
  } rp_level_t;

  typedef enum {TX_IDLE, TX_ARMED, TX_SEND, TX_WAIT} tx_state_t;

  typedef enum {FRS_IDLE, FRS_SIGNAL, FRS_DELAY} frs_state_t;

endpackage : pd_swap_pkg

// ---- hdl/gate_delay_timer.sv ----
module gate_delay_timer #(
  parameter int WIDTH = 17
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // Control
  input wire logic load,
  input wire logic [WIDTH-1:0] load_value,
  // Status
  output logic expire
);

  logic [WIDTH-1:0] count;

  // A load while running restarts the count from the new value
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      count <= '0;
    end else if (load) begin
      count <= load_value;
    end else if (count != '0) begin
      count <= count - 1'b1;
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      expire <= 1'b0;
    end else begin
      expire <= !load && (count == {{(WIDTH-1){1'b0}}, 1'b1});
    end
  end

endmodule : gate_delay_timer

// ---- hdl/pd_vendor_swap_control.sv ----
`include "pd_swap_cfg.svh"

// Contract
// - Dwell select sets source and sink toggle ranges
// - Sink write transmits after Rp goes 1.5A-3.0A
// - Reset and carrier frames sent once, no retry
// - Bit 6 disables sink transmit; reset 0x40
// - Retry field gives zero to three retries
// - Frame field selects frame type to send
// - Automatic sink gate after selected delay
// - Manual mode: device never enables sink gate
// - Writing one starts swap, bit self-clears
// - Arm bit enables detection, clears on detect
// - Alert flags reset zero, write one clears
// - Alert bit0 on swap received, bit1 GPIO-sent
// - Masked alert flags drive interrupt output
module pd_vendor_swap_control #(
  parameter int unsigned GATE_DELAY1_CYC = `GATE_DELAY1_US * `CORE_CLK_MHZ,
  parameter int unsigned GATE_DELAY2_CYC = `GATE_DELAY2_US * `CORE_CLK_MHZ,
  parameter int unsigned GATE_DELAY3_CYC = `GATE_DELAY3_US * `CORE_CLK_MHZ
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  output logic reg_rvalid,
  // Port role and cable-side inputs (asynchronous)
  input wire logic port_is_sink,
  input wire logic [1:0] rp_level_in,
  input wire logic frs_signal_in,
  input wire logic frs_gpio_n_in,
  // Other vendor alert sources, one-cycle pulses
  input wire logic [4:0] other_alert_events,
  // Transmitter
  output logic tx_start,
  output logic tx_busy,
  output pd_swap_pkg::frame_type_t tx_frame_type,
  input wire logic tx_done,
  input wire logic tx_fail,
  // Fast role swap
  output logic frs_tx_req,
  input wire logic frs_tx_done,
  output logic sink_gate_en,
  // Dual-role toggle timing
  output logic [1:0] dual_role_dwell_select,
  output logic [6:0] source_dwell_min_ms,
  output logic [6:0] source_dwell_max_ms,
  output logic [6:0] sink_dwell_min_ms,
  output logic [6:0] sink_dwell_max_ms,
  // Interrupt
  output logic vendor_alert
);
  import pd_swap_pkg::*;

  logic [7:0] toggle_reg;
  logic [7:0] sink_tx_reg;
  logic [7:0] src_frs_reg;
  logic [7:0] snk_frs_reg;
  logic [7:0] alert_flags;
  logic [7:0] alert_mask;
  logic [3:0] sync1, sync2, sync3, pin_q, pin_prev;
  tx_state_t tx_state;
  frs_state_t frs_state;
  logic [1:0] retries_left;
  logic [16:0] gate_delay;
  logic gate_load, gate_expire;
  logic wr_sink_tx, wr_src_frs, wr_snk_frs, wr_alert;
  logic rp_step_up, gpio_fall, frs_detect, frs_go, frs_rx_evt, frs_gpio_evt;
  logic [7:0] alert_set, frs_cfg;
  logic [7:0] next_rdata;

  assign wr_sink_tx = reg_wr && reg_addr == `ADDR_SINK_TX;
  assign wr_src_frs = reg_wr && reg_addr == `ADDR_SRC_FRS;
  assign wr_snk_frs = reg_wr && reg_addr == `ADDR_SNK_FRS;
  assign wr_alert = reg_wr && reg_addr == `ADDR_ALERT;

  // Pin inputs: three flops, accept once stages two and three agree
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      sync1 <= 4'h8;
      sync2 <= 4'h8;
      sync3 <= 4'h8;
      pin_q <= 4'h8;
      pin_prev <= 4'h8;
    end else begin
      sync1 <= {frs_gpio_n_in, frs_signal_in, rp_level_in};
      sync2 <= sync1;
      sync3 <= sync2;
      if (sync2 == sync3) begin
        pin_q <= sync3;
      end
      pin_prev <= pin_q;
    end
  end

  assign rp_step_up = pin_prev[1:0] == RP_1A5 && pin_q[1:0] == RP_3A0;
  assign gpio_fall = pin_prev[3] && !pin_q[3];
  assign frs_detect = pin_q[2] && !pin_prev[2];

  // Toggle timing register and dwell ranges
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      toggle_reg <= `RST_TOGGLE;
    end else if (reg_wr && reg_addr == `ADDR_TOGGLE) begin
      toggle_reg <= reg_wdata & `WMASK_TOGGLE;
    end
  end

  assign dual_role_dwell_select = toggle_reg[1:0];

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      source_dwell_min_ms <= 7'(`SRC_DWELL_BASE_MS);
      source_dwell_max_ms <= 7'(`SRC_DWELL_BASE_MS * `DWELL_SPAN);
      sink_dwell_min_ms <= 7'(`SNK_DWELL_BASE_MS);
      sink_dwell_max_ms <= 7'(`SNK_DWELL_BASE_MS * `DWELL_SPAN);
    end else begin
      source_dwell_min_ms <= 7'(`SRC_DWELL_BASE_MS + `DWELL_STEP_MS * toggle_reg[1:0]);
      source_dwell_max_ms <= 7'((`SRC_DWELL_BASE_MS + `DWELL_STEP_MS * toggle_reg[1:0])
                               * `DWELL_SPAN);
      sink_dwell_min_ms <= 7'(`SNK_DWELL_BASE_MS - `DWELL_STEP_MS * toggle_reg[1:0]);
      sink_dwell_max_ms <= 7'((`SNK_DWELL_BASE_MS - `DWELL_STEP_MS * toggle_reg[1:0])
                             * `DWELL_SPAN);
    end
  end

  // Sink transmit register
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      sink_tx_reg <= `RST_SINK_TX;
    end else if (wr_sink_tx) begin
      sink_tx_reg <= reg_wdata & `WMASK_SINK_TX;
    end
  end

  // Sink transmit sequencer; a write as source is never armed
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      tx_state <= TX_IDLE;
      retries_left <= 2'h0;
      tx_frame_type <= FRAME_SOP;
    end else begin
      unique case (tx_state)
        TX_IDLE, TX_ARMED: begin
          if (wr_sink_tx) begin
            tx_state <= (port_is_sink && !reg_wdata[`SINK_TX_DIS_BIT]) ? TX_ARMED
                                                                       : TX_IDLE;
          end else if (tx_state == TX_ARMED && rp_step_up && port_is_sink) begin
            tx_state <= TX_SEND;
            tx_frame_type <= frame_type_t'(sink_tx_reg[`FRAME_MSB:`FRAME_LSB]);
            retries_left <= (sink_tx_reg[`FRAME_MSB:`FRAME_LSB] >= FRAME_HARD_RESET)
                            ? 2'h0 : sink_tx_reg[`RETRY_MSB:`RETRY_LSB];
          end
        end
        TX_SEND: tx_state <= TX_WAIT;
        TX_WAIT: begin
          if (tx_fail && retries_left != 2'h0) begin
            tx_state <= TX_SEND;
            retries_left <= retries_left - 2'h1;
          end else if (tx_fail || tx_done) begin
            tx_state <= TX_IDLE;
          end
        end
      endcase
    end
  end

  assign tx_start = tx_state == TX_SEND;
  assign tx_busy = tx_state == TX_SEND || tx_state == TX_WAIT;

  // Source fast swap: bit 0 is not stored, it reads as the signaling in flight
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      src_frs_reg <= `RST_SRC_FRS;
    end else if (wr_src_frs) begin
      src_frs_reg <= reg_wdata & `WMASK_SRC_FRS & ~8'h01;
    end
  end

  assign frs_gpio_evt = gpio_fall && frs_state == FRS_IDLE;
  assign frs_go = frs_state == FRS_IDLE
                  && ((wr_src_frs && reg_wdata[`FRS_INIT_BIT]) || gpio_fall);
  assign frs_cfg = wr_src_frs ? (reg_wdata & `WMASK_SRC_FRS) : src_frs_reg;

  always_comb begin
    unique case (src_frs_reg[`GATE_DLY_MSB:`GATE_DLY_LSB])
      2'h1: gate_delay = 17'(GATE_DELAY1_CYC);
      2'h2: gate_delay = 17'(GATE_DELAY2_CYC);
      2'h3: gate_delay = 17'(GATE_DELAY3_CYC);
      default: gate_delay = 17'h00001;
    endcase
  end

  assign gate_load = frs_state == FRS_SIGNAL && frs_tx_done
                     && !src_frs_reg[`MANUAL_GATE_BIT]
                     && src_frs_reg[`GATE_DLY_MSB:`GATE_DLY_LSB] != 2'h0;

  gate_delay_timer #(
    .WIDTH(17)
  ) gate_delay_timer_inst (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .load(gate_load),
    .load_value(gate_delay),
    .expire(gate_expire)
  );

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      frs_state <= FRS_IDLE;
    end else begin
      unique case (frs_state)
        FRS_IDLE: if (frs_go) frs_state <= FRS_SIGNAL;
        FRS_SIGNAL: if (frs_tx_done) frs_state <= gate_load ? FRS_DELAY : FRS_IDLE;
        FRS_DELAY: if (gate_expire) frs_state <= FRS_IDLE;
      endcase
    end
  end

  assign frs_tx_req = frs_state == FRS_SIGNAL;

  // Host owns the gate in manual mode, so the device only ever turns it off
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      sink_gate_en <= 1'b0;
    end else if (frs_go) begin
      sink_gate_en <= !frs_cfg[`MANUAL_GATE_BIT]
                      && frs_cfg[`GATE_DLY_MSB:`GATE_DLY_LSB] == 2'h0;
    end else if (gate_expire && frs_state == FRS_DELAY && !src_frs_reg[`MANUAL_GATE_BIT]) begin
      sink_gate_en <= 1'b1;
    end
  end

  // Sink fast swap detection arm
  assign frs_rx_evt = snk_frs_reg[`FRS_ARM_BIT] && frs_detect;

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      snk_frs_reg <= `RST_SNK_FRS;
    end else if (frs_rx_evt) begin
      snk_frs_reg <= 8'h00;
    end else if (wr_snk_frs) begin
      snk_frs_reg <= reg_wdata & `WMASK_SNK_FRS;
    end
  end

  // Alert flags: a new event beats a same-cycle clear
  assign alert_set = {1'b0, other_alert_events, frs_gpio_evt, frs_rx_evt};

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      alert_flags <= `RST_ALERT;
    end else begin
      alert_flags <= ((alert_flags & ~(wr_alert ? reg_wdata : 8'h00)) | alert_set)
                     & `WMASK_ALERT;
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      alert_mask <= `RST_ALERT_MASK;
    end else if (reg_wr && reg_addr == `ADDR_ALERT_MASK) begin
      alert_mask <= reg_wdata & `WMASK_ALERT;
    end
  end

  assign vendor_alert = |(alert_flags & alert_mask);

  // Read path; unmapped addresses return zero
  always_comb begin
    unique case (reg_addr)
      `ADDR_TOGGLE: next_rdata = toggle_reg;
      `ADDR_SINK_TX: next_rdata = sink_tx_reg;
      `ADDR_SRC_FRS: next_rdata = src_frs_reg | {7'h00, frs_tx_req};
      `ADDR_SNK_FRS: next_rdata = snk_frs_reg;
      `ADDR_ALERT: next_rdata = alert_flags;
      `ADDR_ALERT_MASK: next_rdata = alert_mask;
      default: next_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      reg_rdata <= 8'h00;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= reg_rd;
      if (reg_rd) begin
        reg_rdata <= next_rdata;
      end
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  sequence armed_step_s;
    tx_state == TX_ARMED && rp_step_up && port_is_sink && !wr_sink_tx;
  endsequence

  sequence retry_fail_s;
    tx_state == TX_WAIT && tx_fail && retries_left != 2'h0;
  endsequence

  dwell_map_a: assert property (##1 source_dwell_min_ms
    == 7'(15 + 5 * $past(toggle_reg[1:0])) && sink_dwell_max_ms
    == 7'((35 - 5 * $past(toggle_reg[1:0])) * 2)) else $error("dwell range wrong");
  rp_start_a: assert property (armed_step_s |=> tx_start ##1 !tx_start && tx_busy)
    else $error("sink transmit not started");
  single_shot_a: assert property (armed_step_s
    ##0 sink_tx_reg[2:0] >= 3'h5 |=> retries_left == 2'h0) else $error("reset retried");
  disabled_tx_a: assert property (wr_sink_tx && reg_wdata[6] && !tx_busy |=> tx_state == TX_IDLE)
    else $error("disabled sink transmit armed");
  retry_a: assert property (retry_fail_s |=> tx_start && retries_left
    == $past(retries_left) - 2'h1) else $error("retry not issued");
  frame_sel_a: assert property (armed_step_s |=> tx_frame_type
    == frame_type_t'($past(sink_tx_reg[2:0]))) else $error("frame type wrong");
  gate_cause_a: assert property ($rose(sink_gate_en) |-> $past(frs_go)
    || $past(gate_expire)) else $error("gate enabled without cause");
  manual_gate_a: assert property ($past(src_frs_reg[1]) && src_frs_reg[1] |-> !$rose(sink_gate_en))
    else $error("gate enabled in manual mode");
  swap_start_a: assert property (wr_src_frs && reg_wdata[0] && frs_state == FRS_IDLE
    |=> frs_tx_req until frs_tx_done) else $error("swap not started");
  detect_a: assert property (frs_rx_evt |=> snk_frs_reg[0] == 1'b0 && alert_flags[0])
    else $error("detect not cleared");
  w1c_a: assert property (wr_alert && alert_set == 8'h00 |=> (alert_flags
    & $past(reg_wdata)) == 8'h00) else $error("alert not cleared");
  irq_a: assert property (##1 vendor_alert == |((($past(alert_flags)
    & ~($past(wr_alert) ? $past(reg_wdata) : 8'h00)) | $past(alert_set)) & alert_mask))
    else $error("interrupt mismatch");

endmodule : pd_vendor_swap_control

// ---- dv/pd_phy_partner.sv ----
module pd_phy_partner (
  // Clock
  input wire logic core_clk,
  // Scenario control
  input wire logic fail_all,
  // Transmitter
  input wire logic tx_start,
  output logic tx_done,
  output logic tx_fail,
  // Fast swap signaling
  input wire logic frs_tx_req,
  output logic frs_tx_done
);
  timeunit 1ns;
  timeprecision 1ps;
  int tx_wait = 0;
  int frs_wait = 0;
  initial begin
    tx_done = 1'b0;
    tx_fail = 1'b0;
    frs_tx_done = 1'b0;
  end
  // A frame spends a few cycles on the wire before its result returns
  always @(posedge core_clk) begin
    tx_done <= 1'b0;
    tx_fail <= 1'b0;
    if (tx_start) begin
      tx_wait <= 3;
    end else if (tx_wait == 1) begin
      tx_wait <= 0;
      tx_fail <= fail_all;
      tx_done <= !fail_all;
    end else if (tx_wait > 1) begin
      tx_wait <= tx_wait - 1;
    end
  end
  // Guard on done keeps the request still held in the done cycle from counting toward the next answer
  always @(posedge core_clk) begin
    frs_tx_done <= 1'b0;
    if (frs_tx_req && !frs_tx_done) begin
      if (frs_wait == 4) begin
        frs_tx_done <= 1'b1;
        frs_wait <= 0;
      end else begin
        frs_wait <= frs_wait + 1;
      end
    end
  end
endmodule : pd_phy_partner

// ---- dv/pd_vendor_swap_control_tb.sv ----
module pd_vendor_swap_control_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import pd_swap_pkg::*;
  localparam int D1 = 20;
  localparam int D2 = 40;
  localparam int D3 = 80;
  logic core_clk, sys_rst, reg_wr, reg_rd, reg_rvalid, port_is_sink;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, rv;
  logic [1:0] rp_level_in, dwell_sel;
  logic frs_signal_in, frs_gpio_n_in, tx_start, tx_busy, tx_done, tx_fail;
  logic frs_tx_req, frs_tx_done, sink_gate_en, vendor_alert, fail_all, gate_q;
  logic [4:0] other_alert_events;
  frame_type_t tx_frame_type;
  logic [2:0] last_ft;
  logic [6:0] src_min, src_max, snk_min, snk_max;
  int err_count = 0;
  int n_tests = 0;
  int cyc = 0;
  int starts, done_cyc, gate_cyc, req_cyc;
  pd_vendor_swap_control #(.GATE_DELAY1_CYC(D1), .GATE_DELAY2_CYC(D2),
      .GATE_DELAY3_CYC(D3)) pd_vendor_swap_control_inst (
    .core_clk(core_clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .port_is_sink(port_is_sink),
    .rp_level_in(rp_level_in), .frs_signal_in(frs_signal_in),
    .frs_gpio_n_in(frs_gpio_n_in), .other_alert_events(other_alert_events),
    .tx_start(tx_start), .tx_busy(tx_busy), .tx_frame_type(tx_frame_type),
    .tx_done(tx_done), .tx_fail(tx_fail), .frs_tx_req(frs_tx_req),
    .frs_tx_done(frs_tx_done), .sink_gate_en(sink_gate_en),
    .dual_role_dwell_select(dwell_sel), .source_dwell_min_ms(src_min),
    .source_dwell_max_ms(src_max), .sink_dwell_min_ms(snk_min),
    .sink_dwell_max_ms(snk_max), .vendor_alert(vendor_alert));
  pd_phy_partner pd_phy_partner_inst (
    .core_clk(core_clk), .fail_all(fail_all), .tx_start(tx_start),
    .tx_done(tx_done), .tx_fail(tx_fail), .frs_tx_req(frs_tx_req),
    .frs_tx_done(frs_tx_done));
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    gate_q <= sink_gate_en;
    if (tx_start) begin
      starts <= starts + 1;
      last_ft <= tx_frame_type;
    end
    if (frs_tx_done) done_cyc <= cyc;
    if (sink_gate_en && !gate_q) gate_cyc <= cyc;
    if (frs_tx_req && req_cyc < 0) req_cyc <= cyc;
  end
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge core_clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge core_clk);
    reg_wr = 1'b0;
  endtask : wr
  task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
    int k;
    @(negedge core_clk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge core_clk);
    reg_rd = 1'b0;
    for (k = 0; k < 4 && reg_rvalid !== 1'b1; k++) @(negedge core_clk);
    check({7'h00, reg_rvalid}, 8'h01);
    check(reg_rdata, exp);
  endtask : rchk
  task automatic t_reset();
    logic [7:0] addrs [7] = '{8'hA7, 8'hB0, 8'hB1, 8'hB2, 8'hB3, 8'hB4, 8'hA8};
    logic [7:0] vals [7] = '{8'h00, 8'h40, 8'h00, 8'h00, 8'h00, 8'h7F, 8'h00};
    for (int i = 0; i < 7; i++) rchk(addrs[i], vals[i]);
    check({src_min, src_max[0]}, {7'h0F, 1'b0});
    check({1'b0, snk_max}, 8'h46);
  endtask : t_reset
  task automatic t_dwell();
    for (int i = 0; i < 4; i++) begin
      wr(8'hA7, 8'hFC | 8'(i));
      rchk(8'hA7, 8'(i));
      check({6'h00, dwell_sel}, 8'(i));
      check({src_min, snk_min[0]}, {7'(15 + 5 * i), 1'(35 - 5 * i)});
      check({1'b0, src_max}, 8'(30 + 10 * i));
      check({1'b0, snk_min}, 8'(35 - 5 * i));
      check({1'b0, snk_max}, 8'(70 - 10 * i));
    end
  endtask : t_dwell
  task automatic send_sink(input logic [7:0] val, input int exp);
    int k;
    rp_level_in = RP_1A5;
    repeat (8) @(negedge core_clk);
    wr(8'hB0, val);
    rchk(8'hB0, val & 8'h77);
    starts = 0;
    rp_level_in = RP_3A0;
    for (k = 0; k < 20 && tx_busy !== 1'b1; k++) @(negedge core_clk);
    for (k = 0; k < 200 && tx_busy !== 1'b0; k++) @(negedge core_clk);
    check(8'(starts), 8'(exp));
    if (exp > 0) check({5'h00, last_ft}, {5'h00, val[2:0]});
  endtask : send_sink
  task automatic t_sink_tx();
    for (int i = 0; i < 8; i++) begin
      send_sink(8'h88 | 8'(i) | 8'((i % 4) << 4), (i >= 5) ? 1 : (i % 4) + 1);
    end
    send_sink(8'h70, 0);
    fail_all = 1'b0;
    send_sink(8'h30, 1);
  endtask : t_sink_tx
  task automatic frs_code(input logic [1:0] code, input logic manual);
    int k;
    gate_cyc = -1;
    req_cyc = -1;
    wr(8'hB1, {4'hF, code, manual, 1'b1});
    rchk(8'hB1, {4'h0, code, manual, 1'b1});
    for (k = 0; k < 150 && gate_cyc < 0; k++) @(negedge core_clk);
    if (manual) check(8'(gate_cyc + 1), 8'h00);
    else if (code == 2'h0) check(8'(gate_cyc - req_cyc), 8'h00);
    else check(8'(gate_cyc - done_cyc), 8'((10 << code) + 2));
    for (k = 0; k < 20 && frs_tx_req !== 1'b0; k++) @(negedge core_clk);
    rchk(8'hB1, {4'h0, code, manual, 1'b0});
  endtask : frs_code
  task automatic t_src_frs();
    frs_code(2'h0, 1'b1);
    for (int c = 0; c < 4; c++) frs_code(2'(c), 1'b0);
    req_cyc = -1;
    wr(8'hB1, 8'h00);
    repeat (6) @(negedge core_clk);
    check(8'(req_cyc + 1), 8'h00);
    rchk(8'hB3, 8'h00);
  endtask : t_src_frs
  task automatic t_alerts();
    int k;
    frs_gpio_n_in = 1'b0;
    for (k = 0; k < 20 && frs_tx_req !== 1'b1; k++) @(negedge core_clk);
    for (k = 0; k < 20 && frs_tx_req !== 1'b0; k++) @(negedge core_clk);
    rchk(8'hB3, 8'h02);
    check({7'h00, vendor_alert}, 8'h01);
    wr(8'hB4, 8'h7D);
    check({7'h00, vendor_alert}, 8'h00);
    wr(8'hB3, 8'h00);
    rchk(8'hB3, 8'h02);
    wr(8'hB3, 8'h02);
    rchk(8'hB3, 8'h00);
    frs_gpio_n_in = 1'b1;
    wr(8'hB4, 8'h7F);
    @(negedge core_clk);
    other_alert_events = 5'h1F;
    @(negedge core_clk);
    other_alert_events = 5'h00;
    rchk(8'hB3, 8'h7C);
    check({7'h00, vendor_alert}, 8'h01);
    wr(8'hB3, 8'hFF);
    rchk(8'hB3, 8'h00);
    check({7'h00, vendor_alert}, 8'h00);
  endtask : t_alerts
  task automatic t_sink_detect();
    wr(8'hB2, 8'hFF);
    rchk(8'hB2, 8'h01);
    frs_signal_in = 1'b1;
    repeat (10) @(negedge core_clk);
    rchk(8'hB2, 8'h00);
    rchk(8'hB3, 8'h01);
    frs_signal_in = 1'b0;
    wr(8'hB3, 8'h01);
    repeat (6) @(negedge core_clk);
    frs_signal_in = 1'b1;
    repeat (10) @(negedge core_clk);
    rchk(8'hB3, 8'h00);
    frs_signal_in = 1'b0;
  endtask : t_sink_detect
  task automatic test_done();
    if (err_count == 0 && n_tests > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : test_done
  initial begin
    repeat (30000) @(posedge core_clk);
    err_count++;
    test_done();
  end
  initial begin
    sys_rst = 1'b1;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    port_is_sink = 1'b1;
    rp_level_in = RP_NONE;
    frs_signal_in = 1'b0;
    frs_gpio_n_in = 1'b1;
    other_alert_events = 5'h00;
    fail_all = 1'b1;
    starts = 0;
    done_cyc = 0;
    gate_cyc = -1;
    req_cyc = -1;
    repeat (5) @(negedge core_clk);
    sys_rst = 1'b0;
    t_reset();
    t_dwell();
    t_sink_tx();
    t_src_frs();
    t_alerts();
    t_sink_detect();
    test_done();
  end
endmodule : pd_vendor_swap_control_tb
